// ==== hw/mws_pkg.sv ====
package mws_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes.
    localparam int AXES = 2;
    localparam int ADDR_W = 8;
    localparam int POS_W = 10;
    localparam int CUR_W = 9;
    localparam int TABLE_BITS = 256;
    localparam int TABLE_WORDS = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] OFS_TABLE0 = 8'h00;
    localparam logic [7:0] OFS_SETUP = 8'h20;
    localparam logic [7:0] OFS_START = 8'h24;
    localparam logic [7:0] OFS_CTRL = 8'h28;
    localparam logic [7:0] OFS_HOLDRUN = 8'h2C;
    localparam logic [7:0] OFS_POS0 = 8'h30;
    localparam logic [7:0] OFS_COIL0 = 8'h34;
    localparam logic [7:0] OFS_POS1 = 8'h38;
    localparam logic [7:0] OFS_COIL1 = 8'h3C;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [255:0] TABLE_RST = {
        32'h00404222, 32'h49295556, 32'hB5BB777D, 32'hFBFFFFFF,
        32'h10104222, 32'h24492929, 32'h4A9554AA, 32'hAAAAB554};
    localparam logic [31:0] SETUP_RST = 32'hFFFF8056;
    localparam logic [31:0] START_RST = 32'h00F70000;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] HOLDRUN_RST = 32'h00000000;
    localparam logic signed [8:0] COIL_A_RST = 9'sh000;
    localparam logic signed [8:0] COIL_B_RST = 9'sh0F7;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int SETUP_BND1_LSB = 8;
    localparam int SETUP_BND2_LSB = 16;
    localparam int SETUP_BND3_LSB = 24;
    localparam int START_A_LSB = 0;
    localparam int START_B_LSB = 16;
    localparam int CTRL_DEDGE_LSB = 0;
    localparam int CTRL_RES_LSB = 4;
    localparam int CTRL_EXT_LSB = 12;
    localparam int CTRL_LSPD_LSB = 14;
    localparam int COIL_B_LSB = 16;
    localparam logic [3:0] RES_MAX = 4'h8;
    localparam logic [9:0] HALF_WAVE = 10'h100;

    ////////////////////////////////////////////////////////////////////////
    // Coil current pair.
    typedef struct packed {
        logic signed [8:0] b;
        logic signed [8:0] a;
    } mws_coil_s;

endpackage

// ==== hw/mws_top.sv ====
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
module mws_top (
    // Clock and reset.
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    // Avalon-MM register slave.
    input wire logic [mws_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Step and direction pins, one pair per axis.
    input wire logic [mws_pkg::AXES-1:0] I_STEP,
    input wire logic [mws_pkg::AXES-1:0] I_DIR,
    // Steps from the integrated motion controller.
    input wire logic [mws_pkg::AXES-1:0] I_RAMP_STEP,
    input wire logic [mws_pkg::AXES-1:0] I_RAMP_DIR,
    // Coil currents and mode outputs.
    output mws_pkg::mws_coil_s [mws_pkg::AXES-1:0] O_COIL_CURRENT,
    output logic [mws_pkg::AXES-1:0] O_RAMP_ENABLE,
    output logic [mws_pkg::AXES-1:0] O_LOAD_SPEED_EN,
    output logic [mws_pkg::AXES-1:0][15:0] O_HOLD_RUN
);
    import mws_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wdat,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wdat[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [9:0] step_width(input logic [3:0] res);
        if (res > RES_MAX) begin
            return HALF_WAVE;
        end
        return 10'h001 << res;
    endfunction

    // Sine increment from position pos to pos+1 over the mirrored wave.
    function automatic logic signed [9:0] wave_delta(input logic [9:0] pos, input logic [255:0] tbl,
                                                     input logic [31:0] setup);
        logic [7:0] qi;
        logic [1:0] code;
        logic signed [9:0] d;
        qi = pos[8] ? ~pos[7:0] : pos[7:0];
        if (qi < setup[SETUP_BND1_LSB +: 8]) begin
            code = setup[1:0];
        end else if (qi < setup[SETUP_BND2_LSB +: 8]) begin
            code = setup[3:2];
        end else if (qi < setup[SETUP_BND3_LSB +: 8]) begin
            code = setup[5:4];
        end else begin
            code = setup[7:6];
        end
        d = $signed({8'h00, code}) - 10'sh001;
        d = d + $signed({9'h000, tbl[qi]});
        return (pos[9] ^ pos[8]) ? -d : d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic bus_req;
    logic bus_fire;
    logic [255:0] table_q;
    logic [31:0] setup_q;
    logic [31:0] start_q;
    logic [31:0] ctrl_q;
    logic [31:0] holdrun_q;
    logic [AXES-1:0][9:0] pos_q;
    logic [AXES-1:0][9:0] walk_q;
    logic [AXES-1:0] wdir_q;
    mws_coil_s [AXES-1:0] coil_q;

    assign bus_req = I_AVS_READ | I_AVS_WRITE;
    assign bus_fire = bus_req & ~wait_q;
    assign O_AVS_WAITREQUEST = wait_q;
    assign O_AVS_READDATA = rdata_q;

    // Every request is answered one cycle after it is first seen.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (I_AVS_ADDRESS < OFS_SETUP) begin
            rdata_d = table_q[{I_AVS_ADDRESS[4:2], 5'h00} +: 32];
        end else begin
            case (I_AVS_ADDRESS)
                OFS_SETUP: rdata_d = setup_q;
                OFS_START: rdata_d = start_q;
                OFS_CTRL: rdata_d = ctrl_q;
                OFS_HOLDRUN: rdata_d = holdrun_q;
                OFS_POS0: rdata_d = {22'h0, pos_q[0]};
                OFS_COIL0: rdata_d = {7'h00, coil_q[0].b, 7'h00, coil_q[0].a};
                OFS_POS1: rdata_d = {22'h0, pos_q[1]};
                OFS_COIL1: rdata_d = {7'h00, coil_q[1].b, 7'h00, coil_q[1].a};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_q <= 32'h00000000;
        end else if (I_AVS_READ && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            table_q <= TABLE_RST;
        end else if (I_AVS_WRITE && bus_fire && I_AVS_ADDRESS < OFS_SETUP) begin
            table_q[{I_AVS_ADDRESS[4:2], 5'h00} +: 32] <=
                merge_bytes(table_q[{I_AVS_ADDRESS[4:2], 5'h00} +: 32], I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            setup_q <= SETUP_RST;
            start_q <= START_RST;
            ctrl_q <= CTRL_RST;
            holdrun_q <= HOLDRUN_RST;
        end else if (I_AVS_WRITE && bus_fire) begin
            case (I_AVS_ADDRESS)
                OFS_SETUP: setup_q <= merge_bytes(setup_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                OFS_START: start_q <= merge_bytes(start_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                OFS_CTRL: ctrl_q <= merge_bytes(ctrl_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                OFS_HOLDRUN: holdrun_q <= merge_bytes(holdrun_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step input path.

    logic [AXES-1:0] step_s1_q;
    logic [AXES-1:0] step_s2_q;
    logic [AXES-1:0] step_s3_q;
    logic [AXES-1:0] dir_s1_q;
    logic [AXES-1:0] dir_s2_q;
    logic [AXES-1:0] ext_sel;
    logic [AXES-1:0] pin_edge;
    logic [AXES-1:0] step_fire;
    logic [AXES-1:0] step_dir;

    // two-stage synchronisers, then one stage for edges.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            step_s1_q <= '0;
            step_s2_q <= '0;
            step_s3_q <= '0;
            dir_s1_q <= '0;
            dir_s2_q <= '0;
        end else begin
            step_s1_q <= I_STEP;
            step_s2_q <= step_s1_q;
            step_s3_q <= step_s2_q;
            dir_s1_q <= I_DIR;
            dir_s2_q <= dir_s1_q;
        end
    end

    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            ext_sel[a] = ctrl_q[CTRL_EXT_LSB + a];
            if (ctrl_q[CTRL_DEDGE_LSB + a]) begin
                pin_edge[a] = step_s2_q[a] ^ step_s3_q[a];
            end else begin
                pin_edge[a] = step_s2_q[a] & ~step_s3_q[a];
            end
            step_fire[a] = ext_sel[a] ? pin_edge[a] : I_RAMP_STEP[a];
            step_dir[a] = ext_sel[a] ? dir_s2_q[a] : I_RAMP_DIR[a];
        end
    end

    // ramp and load speed control gated by external mode.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_RAMP_ENABLE <= '1;
            O_LOAD_SPEED_EN <= '0;
        end else begin
            O_RAMP_ENABLE <= ~ext_sel;
            O_LOAD_SPEED_EN <= ctrl_q[CTRL_LSPD_LSB +: AXES] & ~ext_sel;
        end
    end

    // hold and run settings stay live in every mode.
    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            O_HOLD_RUN[a] = holdrun_q[16*a +: 16];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position counter.

    // counter moves by the width of the current resolution.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pos_q <= '0;
            wdir_q <= '0;
        end else begin
            for (int a = 0; a < AXES; a++) begin
                if (step_fire[a]) begin
                    wdir_q[a] <= step_dir[a];
                    if (step_dir[a]) begin
                        pos_q[a] <= pos_q[a] - step_width(ctrl_q[CTRL_RES_LSB + 4*a +: 4]);
                    end else begin
                        pos_q[a] <= pos_q[a] + step_width(ctrl_q[CTRL_RES_LSB + 4*a +: 4]);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wave walker: one table entry per clock towards the counter.

    logic [AXES-1:0][9:0] walk_d;
    logic signed [9:0] da;
    logic signed [9:0] db;
    mws_coil_s [AXES-1:0] coil_d;

    always_comb begin
        da = 10'sh000;
        db = 10'sh000;
        for (int a = 0; a < AXES; a++) begin
            walk_d[a] = walk_q[a];
            coil_d[a] = coil_q[a];
            if (walk_q[a] != pos_q[a]) begin
                if (!wdir_q[a]) begin
                    walk_d[a] = walk_q[a] + 10'h001;
                    da = wave_delta(walk_q[a], table_q, setup_q);
                    db = wave_delta(walk_q[a] + HALF_WAVE, table_q, setup_q);
                end else begin
                    walk_d[a] = walk_q[a] - 10'h001;
                    da = -wave_delta(walk_d[a], table_q, setup_q);
                    db = -wave_delta(walk_d[a] + HALF_WAVE, table_q, setup_q);
                end
                coil_d[a].a = 9'($signed({coil_q[a].a[8], coil_q[a].a}) + da);
                coil_d[a].b = 9'($signed({coil_q[a].b[8], coil_q[a].b}) + db);
                if (walk_d[a] == 10'h000) begin
                    coil_d[a].a = $signed({1'b0, start_q[START_A_LSB +: 8]});
                    coil_d[a].b = $signed({1'b0, start_q[START_B_LSB +: 8]});
                end
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            walk_q <= '0;
            for (int a = 0; a < AXES; a++) begin
                coil_q[a].a <= COIL_A_RST;
                coil_q[a].b <= COIL_B_RST;
            end
        end else begin
            walk_q <= walk_d;
            coil_q <= coil_d;
        end
    end

    assign O_COIL_CURRENT = coil_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks on axis 0 and the register bus.

    logic [9:0] width0;
    logic fall0;
    assign width0 = step_width(ctrl_q[CTRL_RES_LSB +: 4]);
    assign fall0 = ~step_s2_q[0] & step_s3_q[0];

    step_up_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        step_fire[0] && !step_dir[0] |=> pos_q[0] == 10'($past(pos_q[0]) + $past(width0)))
        else $error("position did not advance by the step width");

    step_down_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        step_fire[0] && step_dir[0] |=> pos_q[0] == 10'($past(pos_q[0]) - $past(width0)))
        else $error("position did not retreat by the step width");

    single_edge_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        ext_sel[0] && !ctrl_q[CTRL_DEDGE_LSB] && fall0 |=> $stable(pos_q[0]))
        else $error("falling step edge counted in single-edge mode");

    both_edge_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        ext_sel[0] && ctrl_q[CTRL_DEDGE_LSB] && $changed(step_s2_q[0]) && !$changed(ctrl_q)
        |=> pos_q[0] != $past(pos_q[0]))
        else $error("synchronised step edge missed in double-edge mode");

    zero_load_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        walk_q[0] != pos_q[0] && walk_d[0] == 10'h000
        |=> coil_q[0].a == $signed({1'b0, $past(start_q[7:0])})
        && coil_q[0].b == $signed({1'b0, $past(start_q[23:16])}))
        else $error("coil currents not reloaded at position zero");

    walk_step_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        walk_q[0] != pos_q[0] && !wdir_q[0] |=> walk_q[0] == 10'($past(walk_q[0]) + 10'h001))
        else $error("wave walker did not advance one entry");

    ext_block_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        ext_sel[0] && I_RAMP_STEP[0] && !pin_edge[0] |=> $stable(pos_q[0]))
        else $error("ramp step moved an externally driven axis");

    lspd_off_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        ext_sel[0] ##1 ext_sel[0] |-> !O_LOAD_SPEED_EN[0])
        else $error("load speed control left on under external steps");

    bus_answer_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        bus_req && wait_q |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
        else $error("bus answer not given for exactly one cycle");

    fwd_step_c: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        step_fire[0] && !step_dir[0]);
    back_step_c: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        step_fire[0] && step_dir[0]);
    zero_pass_c: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        walk_q[0] != pos_q[0] && walk_d[0] == 10'h000);
    bus_write_c: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
        I_AVS_WRITE && bus_fire && I_AVS_ADDRESS == OFS_SETUP);

endmodule

// ==== dv/mws_step_source.sv ====
`timescale 1ns/1ns
module mws_step_source (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Requests from the bench.
    input wire logic i_req,
    input wire logic i_dir,
    input wire logic i_toggle,
    // Step and direction pins.
    output logic o_step,
    output logic o_dir,
    output logic o_busy
);
    logic [6:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Direction settles 9 cycles before the edge, pulses last 24 cycles.
    // step spacing
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 7'h00;
            o_step <= 1'b0;
            o_dir <= 1'b0;
        end else if (cnt_q == 7'h00) begin
            if (i_req) begin
                o_dir <= i_dir;
                cnt_q <= 7'h40;
            end
        end else begin
            cnt_q <= cnt_q - 7'h01;
            if (cnt_q == 7'h38) o_step <= i_toggle ? ~o_step : 1'b1;
            if (cnt_q == 7'h20 && !i_toggle) o_step <= 1'b0;
        end
    end
    assign o_busy = (cnt_q != 7'h00);
endmodule

// ==== dv/mws_top_bench.sv ====
`timescale 1ns/1ns
module mws_top_bench;
    import mws_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [1:0] req = 2'h0, sdir = 2'h0, tog = 2'h0, rstep = 2'h0, rdir = 2'h0;
    wire [1:0] step, dir, busy;
    logic [1:0] ramp_en, lspd;
    mws_coil_s [1:0] coil;
    logic [1:0][15:0] hold_run;
    logic [255:0] tbl = TABLE_RST;
    logic [31:0] setup = 32'hFFFF8056;
    logic [31:0] start = 32'h00F70000;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    initial forever #2 clk = ~clk;

    mws_top i_mws_top (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wreq), .I_STEP(step), .I_DIR(dir), .I_RAMP_STEP(rstep), .I_RAMP_DIR(rdir),
        .O_COIL_CURRENT(coil), .O_RAMP_ENABLE(ramp_en), .O_LOAD_SPEED_EN(lspd), .O_HOLD_RUN(hold_run));
    mws_step_source i_mws_step_source0 (.i_clk(clk), .i_rst_n(rst_n), .i_req(req[0]), .i_dir(sdir[0]),
        .i_toggle(tog[0]), .o_step(step[0]), .o_dir(dir[0]), .o_busy(busy[0]));
    mws_step_source i_mws_step_source1 (.i_clk(clk), .i_rst_n(rst_n), .i_req(req[1]), .i_dir(sdir[1]),
        .i_toggle(tog[1]), .o_step(step[1]), .o_dir(dir[1]), .o_busy(busy[1]));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_coil(input string what, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The request stands until waitrequest is sampled low; read data are taken at that same edge.
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av(1'b0, a, 32'h0, q);
        chk_reg(what, exp, q);
    endtask

    task automatic chk_pos(input int ax, input int p);
        logic [31:0] q;
        av(1'b0, (ax == 1) ? OFS_POS1 : OFS_POS0, 32'h0, q);
        chk_reg("position", {22'h0, p[9:0]}, {22'h0, q[9:0]});
    endtask

    task automatic pin_steps(input int ax, input logic d, input logic t, input int n);
        repeat (n) begin
            @(posedge clk);
            req[ax] <= 1'b1;
            sdir[ax] <= d;
            tog[ax] <= t;
            @(posedge clk);
            req[ax] <= 1'b0;
            do @(negedge clk); while (busy[ax] !== 1'b0);
        end
        repeat (300) @(negedge clk);
    endtask

    // Coil A value in the first quarter, accumulated from the start value.
    function automatic logic [8:0] wave(input int p);
        int v;
        int c;
        v = start[7:0];
        for (int i = 0; i < p; i++) begin
            c = (i < setup[15:8]) ? 0 : (i < setup[23:16]) ? 1 : (i < setup[31:24]) ? 2 : 3;
            v += int'(setup[2*c+:2]) - 1 + int'(tbl[i]);
        end
        return v[8:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rd_chk("table word", 8'(i * 4), TABLE_RST[32*i+:32]);
        rd_chk("segment setup", OFS_SETUP, 32'hFFFF8056);
        rd_chk("start values", OFS_START, 32'h00F70000);
        chk_coil("coil a", 9'h000, coil[0].a);
        chk_coil("coil b", 9'h0F7, coil[0].b);
        chk_reg("ramp enable", 32'h3, {30'h0, ramp_en});
        $display("reset test done");
    endtask

    task automatic t_regs;
        wr32(OFS_HOLDRUN, 32'h12345678);
        chk_reg("hold run", 32'h12345678, {hold_run[1], hold_run[0]});
        wr32(8'h1C, 32'h5A5A0F0F);
        tbl[255:224] = 32'h5A5A0F0F;
        rd_chk("table word", 8'h1C, 32'h5A5A0F0F);
        wr32(8'hF0, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'hF0, 32'h0);
        wr32(OFS_POS0, 32'h155);
        chk_pos(0, 0);
        $display("register test done");
    endtask

    task automatic t_walk;
        wr32(OFS_CTRL, 32'h3000);
        for (int p = 1; p <= 20; p++) begin
            pin_steps(0, 1'b0, 1'b0, 1);
            chk_pos(0, p);
            chk_coil("coil a", wave(p), coil[0].a);
        end
        pin_steps(0, 1'b1, 1'b0, 20);
        chk_pos(0, 0);
        chk_coil("coil b", 9'h0F7, coil[0].b);
        $display("walk test done");
    endtask

    task automatic t_segments;
        setup = 32'h0C0804E4;
        wr32(OFS_SETUP, setup);
        tbl[31:0] = 32'h0000F0F0;
        wr32(OFS_TABLE0, tbl[31:0]);
        start = 32'h00640002;
        wr32(OFS_START, start);
        pin_steps(0, 1'b1, 1'b0, 1);
        chk_pos(0, 1023);
        pin_steps(0, 1'b0, 1'b0, 1);
        chk_coil("coil a", 9'h002, coil[0].a);
        chk_coil("coil b", 9'h064, coil[0].b);
        for (int p = 1; p <= 16; p++) begin
            pin_steps(0, 1'b0, 1'b0, 1);
            chk_coil("coil a", wave(p), coil[0].a);
        end
        $display("segment test done");
    endtask

    task automatic t_resolution;
        wr32(OFS_CTRL, 32'h3020);
        pin_steps(0, 1'b0, 1'b0, 3);
        chk_pos(0, 28);
        chk_coil("coil a", wave(28), coil[0].a);
        pin_steps(0, 1'b1, 1'b0, 7);
        chk_pos(0, 0);
        chk_coil("coil a", 9'h002, coil[0].a);
        wr32(OFS_CTRL, 32'h3090);
        pin_steps(0, 1'b0, 1'b0, 1);
        chk_pos(0, 256);
        pin_steps(0, 1'b1, 1'b0, 2);
        chk_pos(0, 768);
        wr32(OFS_CTRL, 32'h3001);
        pin_steps(0, 1'b0, 1'b1, 2);
        chk_pos(0, 770);
        wr32(OFS_CTRL, 32'h3000);
        pin_steps(0, 1'b0, 1'b1, 2);
        chk_pos(0, 771);
        $display("resolution test done");
    endtask

    task automatic t_modes;
        wr32(OFS_CTRL, 32'hE000);
        repeat (4) @(negedge clk);
        chk_reg("ramp enable", 32'h1, {30'h0, ramp_en});
        chk_reg("load speed", 32'h1, {30'h0, lspd});
        pin_steps(0, 1'b0, 1'b0, 1);
        chk_pos(0, 771);
        @(posedge clk);
        rstep[0] <= 1'b1;
        @(posedge clk);
        rstep[0] <= 1'b0;
        repeat (20) @(negedge clk);
        chk_pos(0, 772);
        wr32(OFS_CTRL, 32'hF000);
        repeat (4) @(negedge clk);
        chk_reg("ramp enable", 32'h0, {30'h0, ramp_en});
        chk_reg("load speed", 32'h0, {30'h0, lspd});
        @(posedge clk);
        rstep[0] <= 1'b1;
        @(posedge clk);
        rstep[0] <= 1'b0;
        repeat (20) @(negedge clk);
        chk_pos(0, 772);
        pin_steps(1, 1'b1, 1'b0, 1);
        pin_steps(1, 1'b0, 1'b0, 6);
        chk_pos(1, 5);
        chk_coil("coil a", wave(5), coil[1].a);
        $display("mode test done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_walk();
        t_segments();
        t_resolution();
        t_modes();
        final_report();
    end
endmodule
